// ==== design/pcpl_top.sv ====
// Operation
// - High enable pin powers its rail group.
// - Pins three and six selectable as sleep.
// - Sleep pin low enters sleep, high exits.
// - Sleeping rail uses its own sleep voltage.
// - Open-drain interrupt pin pulls low when pending.
// - First three outputs: open-drain or push-pull.
// - Output may show combined power-good of rails.
// - Output may follow a software register bit.
// - Fourth output always open-drain, both sources.
`timescale 1ns/100ps
`include "pcpl_params.svh"

module pcpl_top #(
    parameter int N_RAILS = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] rail_group_enable_in,
    input wire logic [N_RAILS-1:0] rail_pgood,
    output logic [N_RAILS-1:0] rail_enable,
    output logic [N_RAILS-1:0] rail_sleep,
    output pcpl_pkg::pcpl_vcode_t [N_RAILS-1:0] rail_vout_code,
    output logic general_out_a,
    output logic general_out_a_oe,
    output logic general_out_b,
    output logic general_out_b_oe,
    output logic general_out_c,
    output logic general_out_c_oe,
    output logic general_out_opendrain_d,
    output logic general_out_opendrain_d_oe,
    output logic interrupt_out_low,
    output logic interrupt_out_low_oe
);
    import pcpl_pkg::*;

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // Status packs each rail vector into one byte, so at most eight rails fit.
    if (N_RAILS < 1 || N_RAILS > 8) begin : g_bad_rails
        $error("pcpl_top: N_RAILS must be between 1 and 8");
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base,
                                     input int count);
        return (a >= base) && (a < base + 8'(4 * count)) && (a[1:0] == 2'b00);
    endfunction

    function automatic int bank_index(input logic [7:0] a, input logic [7:0] base);
        return int'((a - base) >> 2);
    endfunction

    // Open drain only ever pulls low; push-pull drives both levels.
    function automatic pcpl_drive_s pin_drive(input logic level, input logic open_drain);
        pcpl_drive_s d;
        if (open_drain) begin
            d.out = 1'b0;
            d.oe = ~level;
        end else begin
            d.out = level;
            d.oe = 1'b1;
        end
        return d;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    logic [5:0] pin;
    logic [N_RAILS-1:0] pg;

    pcpl_sync #(
        .WIDTH(N_RAILS + 6)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({rail_pgood, rail_group_enable_in}),
        .sync_out({pg, pin})
    );

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [N_RAILS-1:0] group_mask [`PCPL_NUM_CTL];
    logic [1:0] sleep_mode;
    logic [N_RAILS-1:0] sleep_grp_a;
    logic [N_RAILS-1:0] sleep_grp_b;
    logic [3:0] gpo_src;
    logic [2:0] gpo_od;
    logic [3:0] gpo_val;
    logic [N_RAILS-1:0] gpo_mask [`PCPL_NUM_GPO];
    logic [N_RAILS-1:0] irq_status;
    logic [N_RAILS-1:0] irq_mask;
    logic [N_RAILS-1:0] pg_prev;
    pcpl_vcode_t vnorm [N_RAILS];
    pcpl_vcode_t vsleep [N_RAILS];

    logic setup;
    logic wr;
    logic next_addr_ok;
    logic [31:0] next_rdata;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        next_addr_ok = 1'b1;
        if (in_bank(paddr, `PCPL_GROUP_BASE, `PCPL_NUM_CTL)) begin
            next_rdata[N_RAILS-1:0] = group_mask[bank_index(paddr, `PCPL_GROUP_BASE)];
        end else if (in_bank(paddr, `PCPL_GPO_MASK_BASE, `PCPL_NUM_GPO)) begin
            next_rdata[N_RAILS-1:0] = gpo_mask[bank_index(paddr, `PCPL_GPO_MASK_BASE)];
        end else if (in_bank(paddr, `PCPL_VNORM_BASE, N_RAILS)) begin
            next_rdata[7:0] = vnorm[bank_index(paddr, `PCPL_VNORM_BASE)];
        end else if (in_bank(paddr, `PCPL_VSLEEP_BASE, N_RAILS)) begin
            next_rdata[7:0] = vsleep[bank_index(paddr, `PCPL_VSLEEP_BASE)];
        end else begin
            unique case (paddr)
                `PCPL_SLEEP_CFG: next_rdata[1:0] = sleep_mode;
                `PCPL_SLEEP_GRP_A: next_rdata[N_RAILS-1:0] = sleep_grp_a;
                `PCPL_SLEEP_GRP_B: next_rdata[N_RAILS-1:0] = sleep_grp_b;
                `PCPL_GPO_CFG: begin
                    next_rdata[`PCPL_GPO_SRC_LSB +: 4] = gpo_src;
                    next_rdata[`PCPL_GPO_OD_LSB +: 3] = gpo_od;
                    next_rdata[`PCPL_GPO_VAL_LSB +: 4] = gpo_val;
                end
                `PCPL_STATUS: begin
                    next_rdata[`PCPL_ST_PG_LSB +: N_RAILS] = pg;
                    next_rdata[`PCPL_ST_EN_LSB +: N_RAILS] = rail_enable;
                    next_rdata[`PCPL_ST_SLP_LSB +: N_RAILS] = rail_sleep;
                    next_rdata[`PCPL_ST_PIN_LSB +: 6] = pin;
                end
                `PCPL_IRQ_STATUS: next_rdata[N_RAILS-1:0] = irq_status;
                `PCPL_IRQ_MASK: next_rdata[N_RAILS-1:0] = irq_mask;
                default: next_addr_ok = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    // The answer is prepared in the setup cycle, so every access phase is one
    // cycle long and the read data come straight from flip-flops.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~next_addr_ok;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Writable configuration
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `PCPL_NUM_CTL; i++) begin
                group_mask[i] <= N_RAILS'(`PCPL_MASK_RST);
            end
            for (int i = 0; i < `PCPL_NUM_GPO; i++) begin
                gpo_mask[i] <= N_RAILS'(`PCPL_MASK_RST);
            end
            sleep_mode <= `PCPL_SLEEP_CFG_RST;
            sleep_grp_a <= N_RAILS'(`PCPL_MASK_RST);
            sleep_grp_b <= N_RAILS'(`PCPL_MASK_RST);
            {gpo_val, gpo_od, gpo_src} <= 11'(`PCPL_GPO_CFG_RST);
            irq_mask <= N_RAILS'(`PCPL_MASK_RST);
        end else if (wr && !pslverr) begin
            if (in_bank(paddr, `PCPL_GROUP_BASE, `PCPL_NUM_CTL)) begin
                group_mask[bank_index(paddr, `PCPL_GROUP_BASE)] <= pwdata[N_RAILS-1:0];
            end
            if (in_bank(paddr, `PCPL_GPO_MASK_BASE, `PCPL_NUM_GPO)) begin
                gpo_mask[bank_index(paddr, `PCPL_GPO_MASK_BASE)] <= pwdata[N_RAILS-1:0];
            end
            if (paddr == `PCPL_SLEEP_CFG) begin
                sleep_mode <= pwdata[1:0];
            end
            if (paddr == `PCPL_SLEEP_GRP_A) begin
                sleep_grp_a <= pwdata[N_RAILS-1:0];
            end
            if (paddr == `PCPL_SLEEP_GRP_B) begin
                sleep_grp_b <= pwdata[N_RAILS-1:0];
            end
            if (paddr == `PCPL_GPO_CFG) begin
                gpo_src <= pwdata[`PCPL_GPO_SRC_LSB +: 4];
                gpo_od <= pwdata[`PCPL_GPO_OD_LSB +: 3];
                gpo_val <= pwdata[`PCPL_GPO_VAL_LSB +: 4];
            end
            if (paddr == `PCPL_IRQ_MASK) begin
                irq_mask <= pwdata[N_RAILS-1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N_RAILS; i++) begin
                vnorm[i] <= `PCPL_VCODE_RST;
                vsleep[i] <= `PCPL_VCODE_RST;
            end
        end else if (wr && !pslverr) begin
            if (in_bank(paddr, `PCPL_VNORM_BASE, N_RAILS)) begin
                vnorm[bank_index(paddr, `PCPL_VNORM_BASE)] <= pwdata[7:0];
            end
            if (in_bank(paddr, `PCPL_VSLEEP_BASE, N_RAILS)) begin
                vsleep[bank_index(paddr, `PCPL_VSLEEP_BASE)] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Power-good loss events
    // ------------------------------------------------------------------------
    // A rail losing power good sets its sticky bit; writing one clears it, but
    // an event in the same cycle wins so that no loss goes unreported.
    logic [N_RAILS-1:0] pg_loss;
    logic [N_RAILS-1:0] irq_clear;

    assign pg_loss = pg_prev & ~pg;
    assign irq_clear = (wr && !pslverr && paddr == `PCPL_IRQ_STATUS) ?
                       pwdata[N_RAILS-1:0] : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pg_prev <= '0;
            irq_status <= '0;
        end else begin
            pg_prev <= pg;
            irq_status <= (irq_status & ~irq_clear) | pg_loss;
        end
    end

    // ------------------------------------------------------------------------
    // Rail enable and sleep
    // ------------------------------------------------------------------------
    logic [5:0] pin_enables;
    logic [N_RAILS-1:0] next_rail_enable;
    logic [N_RAILS-1:0] next_rail_sleep;

    // A pin in sleep use stops acting as an enable for its group.
    always_comb begin
        pin_enables = 6'h3F;
        pin_enables[`PCPL_SLEEP_PIN_A] = ~sleep_mode[0];
        pin_enables[`PCPL_SLEEP_PIN_B] = ~sleep_mode[1];
        next_rail_enable = '0;
        for (int i = 0; i < `PCPL_NUM_CTL; i++) begin
            if (pin_enables[i] && pin[i]) begin
                next_rail_enable = next_rail_enable | group_mask[i];
            end
        end
        next_rail_sleep = '0;
        if (sleep_mode[0] && !pin[`PCPL_SLEEP_PIN_A]) begin
            next_rail_sleep = next_rail_sleep | sleep_grp_a;
        end
        if (sleep_mode[1] && !pin[`PCPL_SLEEP_PIN_B]) begin
            next_rail_sleep = next_rail_sleep | sleep_grp_b;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rail_enable <= '0;
            rail_sleep <= '0;
        end else begin
            rail_enable <= next_rail_enable;
            rail_sleep <= next_rail_sleep;
        end
    end

    // The code follows next_rail_sleep, the value rail_sleep registers, so level and code switch
    // together on the same edge.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rail_vout_code <= '0;
        end else begin
            for (int i = 0; i < N_RAILS; i++) begin
                rail_vout_code[i] <= next_rail_sleep[i] ? vsleep[i] : vnorm[i];
            end
        end
    end

    // ------------------------------------------------------------------------
    // General outputs and interrupt pin
    // ------------------------------------------------------------------------
    logic [3:0] gpo_level;
    pcpl_drive_s drv_a;
    pcpl_drive_s drv_b;
    pcpl_drive_s drv_c;
    pcpl_drive_s drv_d;
    pcpl_drive_s drv_irq;

    // An empty power-good mask reads as good, since no rail is watched.
    always_comb begin
        for (int k = 0; k < `PCPL_NUM_GPO; k++) begin
            if (pcpl_gpo_src_e'(gpo_src[k]) == pcpl_src_reg) begin
                gpo_level[k] = gpo_val[k];
            end else begin
                gpo_level[k] = &(pg | ~gpo_mask[k]);
            end
        end
    end

    assign drv_a = pin_drive(gpo_level[0], gpo_od[0]);
    assign drv_b = pin_drive(gpo_level[1], gpo_od[1]);
    assign drv_c = pin_drive(gpo_level[2], gpo_od[2]);
    assign drv_d = pin_drive(gpo_level[3], 1'b1);
    assign drv_irq = pin_drive(~|(irq_status & irq_mask), 1'b1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            general_out_a <= 1'b0;
            general_out_a_oe <= 1'b0;
            general_out_b <= 1'b0;
            general_out_b_oe <= 1'b0;
            general_out_c <= 1'b0;
            general_out_c_oe <= 1'b0;
            general_out_opendrain_d <= 1'b0;
            general_out_opendrain_d_oe <= 1'b0;
            interrupt_out_low <= 1'b0;
            interrupt_out_low_oe <= 1'b0;
        end else begin
            {general_out_a, general_out_a_oe} <= drv_a;
            {general_out_b, general_out_b_oe} <= drv_b;
            {general_out_c, general_out_c_oe} <= drv_c;
            {general_out_opendrain_d, general_out_opendrain_d_oe} <= drv_d;
            {interrupt_out_low, interrupt_out_low_oe} <= drv_irq;
        end
    end
endmodule

// ==== design/pcpl_params.svh ====
`ifndef PCPL_PARAMS_SVH
`define PCPL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PCPL_GROUP_BASE     8'h00
`define PCPL_SLEEP_CFG      8'h18
`define PCPL_SLEEP_GRP_A    8'h1C
`define PCPL_SLEEP_GRP_B    8'h20
`define PCPL_GPO_CFG        8'h24
`define PCPL_GPO_MASK_BASE  8'h28
`define PCPL_STATUS         8'h38
`define PCPL_IRQ_STATUS     8'h3C
`define PCPL_IRQ_MASK       8'h40
`define PCPL_VNORM_BASE     8'h80
`define PCPL_VSLEEP_BASE    8'hA0

// ----------------------------------------------------------------------------
// Counts and field positions
// ----------------------------------------------------------------------------
`define PCPL_NUM_CTL        6
`define PCPL_NUM_GPO        4
`define PCPL_SLEEP_PIN_A    2
`define PCPL_SLEEP_PIN_B    5
`define PCPL_GPO_SRC_LSB    0
`define PCPL_GPO_OD_LSB     4
`define PCPL_GPO_VAL_LSB    8
`define PCPL_ST_PG_LSB      0
`define PCPL_ST_EN_LSB      8
`define PCPL_ST_SLP_LSB     16
`define PCPL_ST_PIN_LSB     24

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PCPL_VCODE_RST      8'h00
`define PCPL_MASK_RST       8'h00
`define PCPL_GPO_CFG_RST    12'h000
`define PCPL_SLEEP_CFG_RST  2'h0

`endif

// ==== design/pcpl_pkg.sv ====
package pcpl_pkg;

    typedef logic [7:0] pcpl_vcode_t;

    typedef enum logic {
        pcpl_src_pgood = 1'b0,
        pcpl_src_reg = 1'b1
    } pcpl_gpo_src_e;

    typedef struct packed {
        logic out;
        logic oe;
    } pcpl_drive_s;

endpackage

// ==== design/pcpl_sync.sv ====
`timescale 1ns/100ps

module pcpl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ==== tb/pcpl_properties.sv ====
`timescale 1ns/100ps

module pcpl_properties #(
    parameter int N_RAILS = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] rail_group_enable_in,
    input wire logic [N_RAILS-1:0] rail_enable,
    input wire logic [N_RAILS-1:0] rail_sleep,
    input wire logic general_out_a,
    input wire logic general_out_a_oe,
    input wire logic general_out_b,
    input wire logic general_out_b_oe,
    input wire logic general_out_c,
    input wire logic general_out_c_oe,
    input wire logic general_out_opendrain_d,
    input wire logic interrupt_out_low
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------------
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_refusal_zero: assert property (pslverr && !pwrite |->
        pready && prdata == 32'h0000_0000)
        else $error("refused read not zero");

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // A driving-high open-drain pin would fight the board pull-up.
    a_irq_never_high: assert property (!interrupt_out_low)
        else $error("interrupt pin driven high");
    a_gpo_d_open: assert property (!general_out_opendrain_d)
        else $error("fourth output driven high");
    a_gpo_high_drives: assert property ((!general_out_a || general_out_a_oe)
        && (!general_out_b || general_out_b_oe) && (!general_out_c || general_out_c_oe))
        else $error("output high while not enabled");
    a_pins_low_off: assert property ((rail_group_enable_in == 6'h00) [*3] |=>
        rail_enable == '0)
        else $error("rail on with all pins low");
    a_pins_high_awake: assert property ((rail_group_enable_in == 6'h3f) [*3] |=>
        rail_sleep == '0)
        else $error("rail asleep with all pins high");
endmodule

bind pcpl_top pcpl_properties #(.N_RAILS(N_RAILS)) u_props (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rail_group_enable_in(rail_group_enable_in),
    .rail_enable(rail_enable), .rail_sleep(rail_sleep), .general_out_a(general_out_a),
    .general_out_a_oe(general_out_a_oe), .general_out_b(general_out_b),
    .general_out_b_oe(general_out_b_oe), .general_out_c(general_out_c),
    .general_out_c_oe(general_out_c_oe), .general_out_opendrain_d(general_out_opendrain_d),
    .interrupt_out_low(interrupt_out_low));

// ==== tb/pcpl_board.sv ====
`timescale 1ns/100ps

// Board side: pull-ups on every output net, so a released net reads high
// and never shows a stale driven value.
module pcpl_board (
    input wire logic [3:0] gpo_out,
    input wire logic [3:0] gpo_oe,
    input wire logic irq_out,
    input wire logic irq_oe,
    output logic [3:0] gpo_level,
    output logic irq_level
);
    assign gpo_level = (gpo_oe & gpo_out) | ~gpo_oe;
    assign irq_level = irq_oe ? irq_out : 1'b1;
endmodule

// ==== tb/test_pmic_control_pin_logic.sv ====
`timescale 1ns/100ps
`include "pcpl_params.svh"

module test_pmic_control_pin_logic;
    logic clock;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] pins;
    logic [7:0] pg;
    logic [7:0] rail_enable;
    logic [7:0] rail_sleep;
    pcpl_pkg::pcpl_vcode_t [7:0] vout;
    logic [3:0] gpo_out;
    logic [3:0] gpo_oe;
    logic [3:0] gpo_level;
    logic irq_out;
    logic irq_oe;
    logic irq_level;
    logic [31:0] mem [64];
    logic [31:0] r;
    logic [31:0] d;
    logic e;
    logic [7:0] en;
    logic [7:0] sl;
    logic [7:0] npg;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    pcpl_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rail_group_enable_in(pins), .rail_pgood(pg), .rail_enable(rail_enable),
        .rail_sleep(rail_sleep), .rail_vout_code(vout), .general_out_a(gpo_out[0]),
        .general_out_a_oe(gpo_oe[0]), .general_out_b(gpo_out[1]), .general_out_b_oe(gpo_oe[1]),
        .general_out_c(gpo_out[2]), .general_out_c_oe(gpo_oe[2]),
        .general_out_opendrain_d(gpo_out[3]), .general_out_opendrain_d_oe(gpo_oe[3]),
        .interrupt_out_low(irq_out), .interrupt_out_low_oe(irq_oe));

    pcpl_board board (.gpo_out(gpo_out), .gpo_oe(gpo_oe), .irq_out(irq_out), .irq_oe(irq_oe),
        .gpo_level(gpo_level), .irq_level(irq_level));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask

    function automatic bit rw(input int a);
        return a <= 'h34 || a == 'h40 || a >= 'h80;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int a, input logic [31:0] wd);
        apb(1'b1, a[7:0], wd);
        if (a == 'h3c) mem[15] &= ~wd;
        else mem[a >> 2] = wd & (a == 'h18 ? 32'h3 : a == 'h24 ? 32'hf7f : 32'hff);
    endtask

    // Sleep-use pins never enable; a low sleep pin puts its group to sleep.
    task automatic calc;
        en = '0;
        sl = '0;
        for (int p = 0; p < 6; p++) begin
            if (pins[p] && !(p == 2 && mem[6][0]) && !(p == 5 && mem[6][1])) en |= mem[p][7:0];
        end
        if (mem[6][0] && !pins[2]) sl |= mem[7][7:0];
        if (mem[6][1] && !pins[5]) sl |= mem[8][7:0];
    endtask

    task automatic read_all;
        calc();
        for (int a = 0; a < 'hc0; a += 4) begin
            if (rw(a) || a == 'h3c) begin
                apb(1'b0, a[7:0], 32'h0);
                chk("readback", mem[a >> 2], r);
                chk("error flag", 32'h0000_0000, e);
            end
        end
        apb(1'b0, `PCPL_STATUS, 32'h0);
        chk("status", {2'b00, pins, sl, en, pg}, r);
    endtask

    task automatic check_out;
        logic lv;
        logic od;
        calc();
        chk("enable", en, rail_enable);
        chk("sleep", sl, rail_sleep);
        for (int i = 0; i < 8; i++) begin
            chk("vout", sl[i] ? mem[40 + i] : mem[32 + i], vout[i]);
        end
        for (int i = 0; i < 4; i++) begin
            lv = mem[9][i] ? mem[9][8 + i] : &(pg | ~mem[10 + i][7:0]);
            od = i == 3 || mem[9][4 + i];
            chk("gpo level", lv, gpo_level[i]);
            chk("gpo oe", od ? !lv : 1'b1, gpo_oe[i]);
            chk("gpo out", od ? 1'b0 : lv, gpo_out[i]);
        end
        chk("irq level", !(|(mem[15] & mem[16])), irq_level);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pins = 6'h00;
        pg = 8'hff;
        foreach (mem[i]) mem[i] = 32'h0000_0000;
        d = $urandom(32'h576c_0cc0);
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        // A refused write must leave the first group mask as it was.
        apb(1'b1, 8'h02, 32'h0000_00ff);
        chk("refused write", 32'h0000_0001, e);
        read_all();
        // Unmapped and misaligned places are both refused.
        apb(1'b0, 8'h44, 32'h0);
        chk("refused err", 32'h0000_0001, e);
        chk("refused data", 32'h0000_0000, r);
        apb(1'b0, 8'h02, 32'h0);
        chk("misaligned err", 32'h0000_0001, e);
        chk("misaligned data", 32'h0000_0000, r);
        for (int it = 0; it < 20; it++) begin
            for (int a = 0; a < 'hc0; a += 4) begin
                d = $urandom;
                if (a == 'h24) d &= 32'h0000_0f7f;
                if (rw(a)) wr(a, d);
            end
            wr('h3c, 32'h0000_00ff);
            npg = 8'($urandom);
            mem[15] |= {24'h0, pg & ~npg};
            @(posedge clock);
            pins <= it == 0 ? 6'h3f : 6'($urandom);
            pg <= npg;
            repeat (8) @(posedge clock);
            read_all();
            check_out();
        end
        report_and_stop();
    end
endmodule
